// file: verilog/scw_host.sv
// host end: register port orders one full write of eleven bytes
`timescale 1ns/10ps
`include "scw_map.svh"
module scw_host #(
	parameter int HALF_CYC = `SCW_SCL_HALF_CYC
) (
	// clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        nrst_i,
	// register port
	input  wire logic [3:0]  addr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [7:0]  rdata_o,
	// link
	scw_if.host              bus
);
	import scw_pkg::*;
	// refuse half periods that the 16-bit tick counter cannot hold or that leave no room per step
	if (HALF_CYC < 2 || HALF_CYC > 65536) begin : g_half_chk
		$error("half period out of range");
	end
	typedef enum {H_IDLE, H_START, H_BIT, H_STOP} scw_hst_type;
	scw_hst_type  st_ff;             // sequencer state
	scw_byte_type img_ff [`SCW_NUM_DATA]; // data bytes to send
	logic [15:0]  tick_ff;           // half period counter
	logic [1:0]   q_ff;              // quarter within bit
	logic [3:0]   bit_ff;            // bit in byte, 8 is ack
	logic [3:0]   byte_ff;           // byte in sequence
	logic         nack_ff;           // missing acknowledge seen
	logic         scl_ff;
	logic         sda_oe_ff;         // pulls the data line low
	logic         sda_s;
	logic         tick_w;
	scw_byte_type cur_w;
	assign tick_w = tick_ff == 16'(HALF_CYC - 1);
	always_comb begin
		cur_w = 8'h00;
		if (byte_ff == 4'h0)
			cur_w = `SCW_SLAVE_ADDR;                               // RULE1
		else if (byte_ff >= 4'(`SCW_HDR_BYTES))
			cur_w = img_ff[3'(byte_ff - 4'(`SCW_HDR_BYTES))];
	end                                                             // RULE3 RULE4
	scw_sync #(.WIDTH(1)) u_sync (
		.clk_i (core_clk_i),
		.nrst_i(nrst_i),
		.d_i   (bus.sda),
		.q_o   (sda_s)
	);
	//------------------------------------------------------------
	// register writes and reads
	//------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			for (int i = 0; i < `SCW_NUM_DATA; i++)
				img_ff[i] <= 8'h00;
			rdata_o <= 8'h00;
		end else begin
			if (wr_i && addr_i >= `SCW_REG_DATA0)
				img_ff[addr_i[2:0]] <= wdata_i;
			rdata_o <= 8'h00;
			if (rd_i) begin
				if (addr_i == `SCW_REG_STATUS)
					rdata_o <= {6'h00, nack_ff, st_ff != H_IDLE};
				else if (addr_i >= `SCW_REG_DATA0)
					rdata_o <= img_ff[addr_i[2:0]];
			end
		end
	end
	//------------------------------------------------------------
	// bit sequencer, four half-period steps per bit
	//------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_ff     <= H_IDLE;
			tick_ff   <= 16'h0;
			q_ff      <= 2'h0;
			bit_ff    <= 4'h0;
			byte_ff   <= 4'h0;
			nack_ff   <= 1'b0;
			scl_ff    <= 1'b1;
			sda_oe_ff <= 1'b0;
		end else begin
			// half period counter runs only while a transfer is in flight
			tick_ff <= (st_ff == H_IDLE || tick_w) ? 16'h0 : tick_ff + 16'h1;
			unique case (st_ff)
				// wait for go; a second go while busy is ignored
				H_IDLE: if (wr_i && addr_i == `SCW_REG_CTRL && wdata_i[`SCW_CTRL_GO]) begin
					st_ff   <= H_START;
					nack_ff <= 1'b0;
					byte_ff <= 4'h0;
					bit_ff  <= 4'h0;
				end
				// data pulled low while clock stays high marks the start
				H_START: if (tick_w) begin
					sda_oe_ff <= 1'b1;                                  // RULE11
					st_ff     <= H_BIT;
					q_ff      <= 2'h0;
				end
				H_BIT: if (tick_w) begin
					q_ff <= q_ff + 2'h1;
					unique case (q_ff)
						// clock low
						2'h0: scl_ff <= 1'b0;
						// data moves only while clock is low, ack slot releases the line
						2'h1: sda_oe_ff <= (bit_ff == 4'h8) ? 1'b0 : !cur_w[3'(4'h7 - bit_ff)]; // RULE8
						// clock high
						2'h2: scl_ff <= 1'b1;
						// end of bit, acknowledge sampled in the ninth slot
						2'h3: begin
							if (bit_ff == 4'h8) begin
								if (sda_s)
									nack_ff <= 1'b1;                          // RULE11
								bit_ff <= 4'h0;
								if (byte_ff == 4'(`SCW_HDR_BYTES + `SCW_NUM_DATA - 1))
									st_ff <= H_STOP;
								else
									byte_ff <= byte_ff + 4'h1;
							end else begin
								bit_ff <= bit_ff + 4'h1;
							end
						end
					endcase
				end
				// clock low, data low, clock high, then data released: stop
				H_STOP: if (tick_w) begin
					q_ff <= q_ff + 2'h1;
					unique case (q_ff)
						2'h0: scl_ff <= 1'b0;
						2'h1: sda_oe_ff <= 1'b1;
						2'h2: scl_ff <= 1'b1;
						2'h3: begin
							sda_oe_ff <= 1'b0;                              // RULE11
							st_ff     <= H_IDLE;
						end
					endcase
				end
			endcase
		end
	end
	assign bus.scl_o       = scl_ff;
	assign bus.sda_host_o  = 1'b0;
	assign bus.sda_host_oe = sda_oe_ff;
endmodule

// file: verilog/scw_map.svh
// constants for the serial configuration write link
// Operation
// RULE1: answer only address byte 11010010 with write
// RULE2: wrong address leaves configuration untouched
// RULE3: second byte counted, value discarded
// RULE4: third byte counted, never limits length
// RULE5: next bytes fill configuration bytes zero..seven
// RULE6: each written bit drives its function output
// RULE7: host writes reserved bits as zero; scw_host sends them as written to its register port
// RULE8: bits shifted most significant first
// RULE9: write only, no read path
// RULE10: defaults loaded at reset
// RULE11: start, per-byte acknowledge, stop framing
`ifndef SCW_MAP_SVH
`define SCW_MAP_SVH
//------------------------------------------------------------
// addresses and layout
//------------------------------------------------------------
`define SCW_SLAVE_ADDR   8'hd2
`define SCW_NUM_DATA     8
`define SCW_HDR_BYTES    3
// default image, byte 7 down to byte 0
`define SCW_DEFAULTS     64'h0000_7060_0000_0000
// bits the host may set, byte 7 down to byte 0; every other bit is reserved and goes out as written to the host register port
`define SCW_WRITABLE     64'h0000_f0ff_0000_0000
//------------------------------------------------------------
// host register port offsets
//------------------------------------------------------------
`define SCW_REG_CTRL     4'h0
`define SCW_REG_STATUS   4'h1
`define SCW_REG_DATA0    4'h8
`define SCW_CTRL_GO      0
`define SCW_STAT_BUSY    0
`define SCW_STAT_NACK    1
//------------------------------------------------------------
// timing
//------------------------------------------------------------
`define SCW_SCL_HALF_NS  2500
`define SCW_CLK_NS       25
`define SCW_SCL_HALF_CYC ((`SCW_SCL_HALF_NS + `SCW_CLK_NS - 1) / `SCW_CLK_NS)
`endif

// file: verilog/scw_pkg.sv
// types shared by both ends of the serial configuration link
package scw_pkg;
	typedef logic [7:0] scw_byte_type;
	typedef enum logic [1:0] {SCW_IDLE_PH, SCW_ADDR_PH, SCW_HDR_PH, SCW_DATA_PH} scw_phase_type;
endpackage

// file: verilog/scw_if.sv
// two-wire link between host and configuration receiver
`timescale 1ns/10ps
interface scw_if;
	logic link_clk;          // receiver side clock
	logic scl_o;             // serial_clock_line driven by host
	logic sda_host_o;        // host data out
	logic sda_host_oe;       // host drives data
	logic sda_dev_o;         // device data out
	logic sda_dev_oe;        // device drives data
	logic sda;               // resolved open-drain level
	assign sda = !((sda_host_oe && !sda_host_o) || (sda_dev_oe && !sda_dev_o));
	modport host (output scl_o, output sda_host_o, output sda_host_oe, input sda);
	modport dev  (input link_clk, input scl_o, input sda, output sda_dev_o, output sda_dev_oe);
endinterface

// file: verilog/scw_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/10ps
module scw_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             nrst_i,
	// levels
	input  wire logic [WIDTH-1:0] d_i,
	output logic      [WIDTH-1:0] q_o
);
	logic [WIDTH-1:0] meta_ff; // first stage, read only by q_o
	// -------------------------------------------
	// two stages
	// -------------------------------------------
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			meta_ff <= '1;
			q_o     <= '1;
		end else begin
			meta_ff <= d_i;
			q_o     <= meta_ff;
		end
	end
endmodule

// file: verilog/scw_dev.sv
// configuration receiver end, oversamples the two-wire pins on the link clock
`timescale 1ns/10ps
`include "scw_map.svh"
module scw_dev (
	// reset
	input  wire logic          nrst_i,
	// link
	scw_if.dev                 bus,
	// configuration outputs
	output logic [63:0]        cfg_o,
	output logic               cfg_upd_o
);
	import scw_pkg::*;
	logic          scl_s;           // synchronised clock line
	logic          sda_s;           // synchronised data line
	logic          scl_d_ff;        // previous clock level
	logic          sda_d_ff;        // previous data level
	scw_phase_type phase_ff;        // transfer phase
	logic [3:0]    bit_ff;          // bit count in byte
	logic [3:0]    idx_ff;          // byte index after header
	logic [1:0]    hdr_ff;          // header bytes seen
	scw_byte_type  shift_ff;        // assembling byte
	logic          ack_ff;          // driving acknowledge
	logic [63:0]   cfg_ff;          // configuration bytes
	logic          upd_ff;          // write pulse
	logic          start_w;
	logic          stop_w;
	logic          rise_w;
	logic          fall_w;
	//------------------------------------------------------------
	// pin synchronisers
	//------------------------------------------------------------
	scw_sync #(.WIDTH(2)) u_sync (
		.clk_i (bus.link_clk),
		.nrst_i(nrst_i),
		.d_i   ({bus.scl_o, bus.sda}),
		.q_o   ({scl_s, sda_s})
	);
	always_ff @(posedge bus.link_clk or negedge nrst_i) begin
		if (!nrst_i) begin
			scl_d_ff <= 1'b1;
			sda_d_ff <= 1'b1;
		end else begin
			scl_d_ff <= scl_s;
			sda_d_ff <= sda_s;
		end
	end
	assign start_w = scl_s && scl_d_ff && sda_d_ff && !sda_s;  // RULE11
	assign stop_w  = scl_s && scl_d_ff && !sda_d_ff && sda_s;  // RULE11
	assign rise_w  = scl_s && !scl_d_ff;
	assign fall_w  = !scl_s && scl_d_ff;
	//------------------------------------------------------------
	// byte framing and phase
	//------------------------------------------------------------
	always_ff @(posedge bus.link_clk or negedge nrst_i) begin
		if (!nrst_i) begin
			phase_ff <= SCW_IDLE_PH;
			bit_ff   <= 4'h0;
			idx_ff   <= 4'h0;
			hdr_ff   <= 2'h0;
			shift_ff <= 8'h00;
			ack_ff   <= 1'b0;
		end else if (start_w) begin
			phase_ff <= SCW_ADDR_PH;
			bit_ff   <= 4'h0;
			idx_ff   <= 4'h0;
			hdr_ff   <= 2'h1;
			ack_ff   <= 1'b0;
		end else if (stop_w) begin
			phase_ff <= SCW_IDLE_PH;                            // RULE11
			ack_ff   <= 1'b0;
		end else if (phase_ff != SCW_IDLE_PH) begin
			if (rise_w && bit_ff < 4'h8) begin
				shift_ff <= {shift_ff[6:0], sda_s};                // RULE8
				bit_ff   <= bit_ff + 4'h1;
			end else if (fall_w && bit_ff == 4'h8) begin
				// byte complete, decide acknowledge
				bit_ff <= 4'h9;
				unique case (phase_ff)
					SCW_ADDR_PH: begin
						if (shift_ff == `SCW_SLAVE_ADDR) begin     // RULE1 RULE9
							ack_ff   <= 1'b1;
							phase_ff <= SCW_HDR_PH;
						end else begin
							phase_ff <= SCW_IDLE_PH;               // RULE2
						end
					end
					SCW_HDR_PH: begin
						ack_ff <= 1'b1;
						hdr_ff <= hdr_ff + 2'h1;                   // RULE3 RULE4
						if (hdr_ff == 2'(`SCW_HDR_BYTES - 1))
							phase_ff <= SCW_DATA_PH;
					end
					SCW_DATA_PH: begin
						ack_ff <= idx_ff < 4'(`SCW_NUM_DATA);
						if (idx_ff < 4'(`SCW_NUM_DATA))
							idx_ff <= idx_ff + 4'h1;
					end
					SCW_IDLE_PH: ack_ff <= 1'b0;
				endcase
			end else if (fall_w && bit_ff == 4'h9) begin
				ack_ff <= 1'b0;                                     // RULE11
				bit_ff <= 4'h0;
			end
		end
	end
	//------------------------------------------------------------
	// configuration store
	//------------------------------------------------------------
	always_ff @(posedge bus.link_clk or negedge nrst_i) begin
		if (!nrst_i) begin
			cfg_ff <= `SCW_DEFAULTS;                               // RULE10
			upd_ff <= 1'b0;
		end else begin
			upd_ff <= 1'b0;
			if (phase_ff == SCW_DATA_PH && fall_w && bit_ff == 4'h8 &&
			    idx_ff < 4'(`SCW_NUM_DATA)) begin                   // RULE5
				cfg_ff[idx_ff[2:0]*8 +: 8] <= shift_ff;
				upd_ff <= 1'b1;
			end
		end
	end
	assign cfg_o          = cfg_ff;                                // RULE6
	assign cfg_upd_o      = upd_ff;
	assign bus.sda_dev_o  = 1'b0;
	assign bus.sda_dev_oe = ack_ff;                                // RULE9
endmodule

// file: test/scw_chk.sv
// link timing checker for the host and receiver ends
`timescale 1ns/10ps
`include "scw_map.svh"
module scw_chk (
	// link domain
	input  wire logic        link_clk,
	input  wire logic        nrst_i,
	input  wire logic        scl_o,
	input  wire logic        sda_host_oe,
	input  wire logic        sda_dev_oe,
	input  wire logic        sda,
	input  wire logic [63:0] cfg_o,
	input  wire logic        cfg_upd_o
);
	default clocking @(posedge link_clk); endclocking
	default disable iff (!nrst_i);
	property p_ack_start; $rose(sda_dev_oe) |-> !scl_o; endproperty
	a_ack_start: assert property (p_ack_start) else $error("ack began with clock high");
	property p_ack_len; $rose(sda_dev_oe) |-> sda_dev_oe[*8]; endproperty
	a_ack_len: assert property (p_ack_len) else $error("ack too short");
	property p_ack_end; $rose(sda_dev_oe) |-> ##[8:60] !sda_dev_oe; endproperty
	a_ack_end: assert property (p_ack_end) else $error("ack never released");
	property p_ack_rel; ($fell(sda_dev_oe) && $past(nrst_i)) |-> !scl_o; endproperty
	a_ack_rel: assert property (p_ack_rel) else $error("ack released with clock high");
	property p_no_read; (sda_dev_oe && scl_o) |-> !sda_host_oe; endproperty
	a_no_read: assert property (p_no_read) else $error("both ends drive data");
	property p_upd_ack; cfg_upd_o |-> ##[0:3] sda_dev_oe; endproperty
	a_upd_ack: assert property (p_upd_ack) else $error("store without ack");
	property p_upd_pulse; cfg_upd_o |=> !cfg_upd_o; endproperty
	a_upd_pulse: assert property (p_upd_pulse) else $error("store pulse too long");
	property p_cfg_hold; ($changed(cfg_o) && $past(nrst_i)) |-> (cfg_upd_o || $past(cfg_upd_o)); endproperty
	a_cfg_hold: assert property (p_cfg_hold) else $error("config changed without store");
	property p_rst_dflt; $rose(nrst_i) |-> cfg_o == `SCW_DEFAULTS; endproperty
	a_rst_dflt: assert property (p_rst_dflt) else $error("configuration not at defaults");
endmodule

// file: test/scw_tb.sv
// self-checking bench joining host and receiver ends
`timescale 1ns/10ps
`include "scw_map.svh"
module scw_tb;
	logic        clk = 1'b0;   // core clock
	logic        lk = 1'b0;    // link clock
	logic        nrst = 1'b0;  // reset, active low
	logic [3:0]  addr = 4'h0;
	logic [7:0]  wdata = 8'h00;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [7:0]  rdata;
	logic [63:0] cfg, cfg2, keep, exp_cfg;
	logic        upd, upd2, a;
	logic [31:0] seed = 32'h1e4e;
	logic [8:0]  sh = 9'h000;  // wire shift register
	logic [7:0]  s;
	logic [7:0]  mon [0:15];   // bytes seen on the wire
	logic        ackm [0:15];  // ack bit after each byte
	logic [7:0]  wb [0:8];     // bytes the bench sends
	int          bitn = 0, nb = 0, upd_n = 0, failures = 0, check_count = 0;
	scw_if ifm ();
	scw_if ifw ();
	assign ifm.link_clk = lk;
	assign ifw.link_clk = lk;
	always #12.5 clk = ~clk;
	// link clock with an unrelated phase
	initial begin
		#17;
		forever #62.5 lk = ~lk;
	end
	scw_host #(.HALF_CYC(40)) u_scw_host (.core_clk_i(clk), .nrst_i(nrst), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr), .rd_i(rd), .rdata_o(rdata), .bus(ifm.host));
	scw_dev u_scw_dev (.nrst_i(nrst), .bus(ifm.dev), .cfg_o(cfg), .cfg_upd_o(upd));
	scw_dev u_scw_dev_w (.nrst_i(nrst), .bus(ifw.dev), .cfg_o(cfg2), .cfg_upd_o(upd2));
	scw_chk u_scw_chk (.link_clk(ifm.link_clk), .nrst_i(nrst), .scl_o(ifm.scl_o), .sda_host_oe(ifm.sda_host_oe),
		.sda_dev_oe(ifm.sda_dev_oe), .sda(ifm.sda), .cfg_o(cfg), .cfg_upd_o(upd));
	//------------------------------------------------------------
	// wire monitor: rebuild bytes and acks
	//------------------------------------------------------------
	always @(posedge ifm.scl_o) begin
		sh = {sh[7:0], ifm.sda};
		bitn++;
		if (bitn == 9) begin
			mon[nb] = sh[8:1];
			ackm[nb] = sh[0];
			nb++;
			bitn = 0;
		end
	end
	always @(posedge lk) if (upd === 1'b1) upd_n++;
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	// expected image with byte n replaced
	function automatic logic [63:0] put(input logic [63:0] v, input int n, input logic [7:0] d);
		v[n*8 +: 8] = d;
		return v;
	endfunction
	// writable bits of data byte n, reserved bits must go out as zero
	function automatic logic [7:0] wmask(input int n);
		logic [63:0] m;
		m = `SCW_WRITABLE;
		return m[n*8 +: 8];
	endfunction
	task chk(input string nm, input logic [63:0] seen, input logic [63:0] want);
		check_count++;
		if (seen !== want) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, want, seen);
		end
	endtask
	task wr_reg(input logic [3:0] ad, input logic [7:0] d);
		@(posedge clk);
		addr <= ad;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rd_reg(input logic [3:0] ad, output logic [7:0] d);
		@(posedge clk);
		addr <= ad;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		d = rdata;
	endtask
	task hw;
		repeat (40) @(posedge clk);
	endtask
	// one bit on the bench link, returns the level while clock high
	task wbit(input logic b, output logic sv);
		ifw.scl_o <= 1'b0;
		hw;
		ifw.sda_host_oe <= !b;
		hw;
		ifw.scl_o <= 1'b1;
		hw;
		sv = ifw.sda;
		hw;
	endtask
	// start, bytes with ack check, stop
	task xfer(input int nby, input logic ack_w);
		ifw.sda_host_oe <= 1'b1;
		hw;
		for (int i = 0; i < nby; i++) begin
			for (int k = 7; k >= 0; k--) wbit(wb[i][k], a);
			wbit(1'b1, a);
			chk("bench_ack", a, ack_w);
		end
		ifw.scl_o <= 1'b0;
		hw;
		ifw.sda_host_oe <= 1'b1;
		hw;
		ifw.scl_o <= 1'b1;
		hw;
		ifw.sda_host_oe <= 1'b0;
		hw;
	endtask
	task results;
		if (failures == 0 && check_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (90000) @(posedge clk);
		failures++;
		results;
	end
	//------------------------------------------------------------
	// main sequence
	//------------------------------------------------------------
	initial begin
		ifw.scl_o = 1'b1;
		ifw.sda_host_o = 1'b0;
		ifw.sda_host_oe = 1'b0;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		repeat (4) @(posedge clk);
		chk("cfg_rst", cfg, `SCW_DEFAULTS);
		chk("cfg2_rst", cfg2, `SCW_DEFAULTS);
		keep = `SCW_DEFAULTS;
		exp_cfg = `SCW_DEFAULTS;
		rd_reg(4'h1, s);
		chk("status_rst", s, 8'h00);
		rd_reg(4'h7, s);
		chk("unmapped", s, 8'h00);
		for (int t = 0; t < 3; t++) begin
			for (int n = 0; n < 8; n++) begin
				seed = xs(seed);
				s = ((t == 0) ? {8{n[0]}} : seed[7:0]) & wmask(n);
				exp_cfg = put(exp_cfg, n, s);
				wr_reg(4'h8 + n[3:0], s);
			end
			rd_reg(4'hc, s);
			chk("data4_rb", s, exp_cfg[39:32]);
			bitn = 0;
			nb = 0;
			upd_n = 0;
			wr_reg(4'h0, 8'h01);
			rd_reg(4'h1, s);
			chk("busy", s[0], 1'b1);
			wr_reg(4'h0, 8'h01);
			for (int w = 0; w < 12000 && s[0] !== 1'b0; w++) rd_reg(4'h1, s);
			repeat (100) @(posedge clk);
			chk("status", s, 8'h00);
			chk("cfg", cfg, exp_cfg);
			chk("bytes", nb, 11);
			chk("addr", mon[0], 8'hd2);
			for (int n = 0; n < 8; n++) chk("wire_data", mon[3+n], exp_cfg[n*8 +: 8]);
			for (int n = 0; n < 11; n++) chk("wire_ack", ackm[n], 1'b0);
			chk("stores", upd_n, 8);
		end
		// bytes meant for another receiver may carry anything
		wb = '{8'hd0, 8'h00, 8'h03, 8'h5a, 8'ha5, 8'h3c, 8'h00, 8'h00, 8'h00};
		xfer(6, 1'b1);
		repeat (20) @(posedge clk);
		chk("wrong_addr", cfg2, keep);
		seed = xs(seed);
		// byte count says one, yet bytes four and five must still land
		wb = '{8'hd2, seed[7:0], 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, seed[15:8], seed[23:16] & wmask(5)};
		xfer(9, 1'b0);
		repeat (20) @(posedge clk);
		chk("count_ignored", cfg2, put(put(keep, 4, seed[15:8]), 5, seed[23:16] & wmask(5)));
		results;
	end
endmodule
